// [core/hwm_cfg.svh]
`ifndef HWM_CFG_SVH
`define HWM_CFG_SVH
`define HWM_IDX_PORT_DEFAULT   16'h0295
`define HWM_DATA_PORT_DEFAULT  16'h0296
`define HWM_PORT_HIGH_MASK     16'hFFF8
`define HWM_REG_TEMP1          7'h27
`define HWM_REG_TEMP2_HIGH     7'h50
`define HWM_REG_TEMP2_LOW      7'h51
`define HWM_REG_VOLT_BASE      7'h20
`define HWM_REG_FAN_BASE       7'h28
`define HWM_REG_CONFIG         7'h40
`define HWM_REG_ALARM_STATUS   7'h41
`define HWM_REG_ALARM_MASK     7'h43
`define HWM_REG_ROUTE          7'h45
`define HWM_REG_BANK_SEL       7'h4E
`define HWM_REG_HIGH_LIM_BASE  7'h2B
`define HWM_REG_LOW_LIM_BASE   7'h2C
`define HWM_ROUTE_PME_BIT      0
`define HWM_ROUTE_OE_BIT       1
`define HWM_ROUTE_ACPI_BIT     2
`define HWM_CFG_BEEP_BIT       1
`define HWM_CFG_GPO_BIT        2
`define HWM_RST_MASK           8'hFF
`define HWM_RST_HIGH_LIM       8'hFF
`define HWM_RST_LOW_LIM        8'h00
`define HWM_TEMP2_OVT_LIMIT    9'h0AA
`endif

// [core/hwm_pkg.sv]
package hwm_pkg;
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } hwm_io_req_t;

    typedef struct packed {
        logic alarm_event;
        logic pme_route;
        logic out_enable;
        logic acpi_mode;
    } hwm_route_t;
endpackage

// [core/hwm_readout.sv]
// Behaviour
// - Event logic gives system-management alarm in legacy mode, power event in ACPI mode; the code ignores the ACPI bit and steers by route select bit 0.
// - Event goes to system-management pin only when route select 0 and enable 1.
// - Event goes to power-event pin only when route select 1 and enable 1.
// - Index port decoded at 295h, data port at 296h; host uses both.
// - Port address bits two to zero come from configuration indices 5h and 6h.
// - Device supplies all port address bits above the selectable low bits.
// - Each voltage reading is 8-bit unsigned code, 16 mV step, 4.096 V full scale.
// - Sensor one reads as 8-bit two's-complement degrees at index 27h.
// - Sensor two is 9-bit; high eight at bank 1 50h, LSB at 51h bit 7.
// - Sensor two uses half-degree steps; sensor one whole degrees.
// - Seven voltages, two fans, two temperatures, one intrusion input readable.
// - Alarm over serial IRQ; dedicated over-temperature and protection pins driven.
// - Voltages compared to upper and lower limits; maskable alarm and optional beep.
`include "hwm_cfg.svh"
module hwm_readout #(
    parameter int NUM_VOLT = 7,
    parameter int NUM_FAN  = 2
) (
    input  wire logic                 clk_i,
    input  wire logic                 sys_rst_i,
    input  wire hwm_pkg::hwm_io_req_t io_req_i,
    output logic [7:0]                io_rdata_o,
    output logic                      io_hit_o,
    input  wire logic [2:0]           idx_low_cfg_i,
    input  wire logic [2:0]           data_low_cfg_i,
    input  wire logic [7:0]           volt_code_i [NUM_VOLT],
    input  wire logic                 volt_valid_i,
    input  wire logic [7:0]           fan_count_i [NUM_FAN],
    input  wire logic [7:0]           temp1_code_i,
    input  wire logic [8:0]           temp2_code_i,
    input  wire logic                 intrusion_i,
    output logic                      system_mgmt_alarm_out_o,
    output logic                      power_event_out_o,
    output logic                      serirq_alarm_o,
    output logic                      overtemp_out_o,
    output logic                      general_protection_out_o,
    output logic                      beep_o
);
    // Register map only has room for these counts
    if (NUM_VOLT != 7 || NUM_FAN != 2) begin : g_bad_counts
        $error("Channel counts must match the register map");
    end

    logic [7:0]  volt_r [NUM_VOLT];
    logic [7:0]  high_lim [NUM_VOLT];
    logic [7:0]  low_lim [NUM_VOLT];
    logic [7:0]  temp1_r;
    logic [8:0]  temp2_r;
    logic [1:0]  intr_sync;
    logic [6:0]  index;
    logic        bank;
    logic [7:0]  config_reg;
    logic [7:0]  alarm_status;
    logic [7:0]  alarm_mask;
    logic [2:0]  route_reg;
    logic [7:0]  next_read;
    logic [15:0] idx_addr;
    logic [15:0] data_addr;
    logic        idx_hit;
    logic        data_hit;
    logic        data_rd;
    logic        data_wr;
    logic [6:0]  out_of_range;
    logic [7:0]  raw_events;
    logic        combined_event;

    // Only the low three bits move; the upper decode is fixed.
    assign idx_addr  = (`HWM_IDX_PORT_DEFAULT & `HWM_PORT_HIGH_MASK) | {13'h0, idx_low_cfg_i};
    assign data_addr = (`HWM_DATA_PORT_DEFAULT & `HWM_PORT_HIGH_MASK) | {13'h0, data_low_cfg_i};
    assign idx_hit   = io_req_i.addr == idx_addr;
    assign data_hit  = io_req_i.addr == data_addr;
    assign data_rd   = io_req_i.rd && data_hit;
    assign data_wr   = io_req_i.wr && data_hit;
    assign io_hit_o  = (io_req_i.rd || io_req_i.wr) && (idx_hit || data_hit);

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            intr_sync <= 2'h0;
        end else begin
            intr_sync <= {intr_sync[0], intrusion_i};
        end
    end

    // Converter results latched as 8-bit, 16 mV codes
    generate
        for (genvar i = 0; i < NUM_VOLT; i++) begin : g_volt
            always_ff @(posedge clk_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    volt_r[i] <= 8'h00;
                end else if (volt_valid_i) begin
                    volt_r[i] <= volt_code_i[i];
                end
            end
            assign out_of_range[i] = volt_r[i] > high_lim[i] || volt_r[i] < low_lim[i];
            always_ff @(posedge clk_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    high_lim[i] <= `HWM_RST_HIGH_LIM;
                    low_lim[i]  <= `HWM_RST_LOW_LIM;
                end else if (data_wr && !bank) begin
                    if (index == `HWM_REG_HIGH_LIM_BASE + 7'(2 * i))
                        high_lim[i] <= io_req_i.wdata;
                    if (index == `HWM_REG_LOW_LIM_BASE + 7'(2 * i))
                        low_lim[i] <= io_req_i.wdata;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            temp1_r <= 8'h00;
            temp2_r <= 9'h000;
        end else if (volt_valid_i) begin
            temp1_r <= temp1_code_i;
            temp2_r <= temp2_code_i;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            index <= 7'h00;
        end else if (io_req_i.wr && idx_hit) begin
            index <= io_req_i.wdata[6:0];
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            bank       <= 1'b0;
            config_reg <= 8'h00;
            alarm_mask <= `HWM_RST_MASK;
            route_reg  <= 3'h0;
        end else if (data_wr) begin
            unique case (index)
                `HWM_REG_BANK_SEL: bank       <= io_req_i.wdata[0];
                `HWM_REG_CONFIG:   config_reg <= io_req_i.wdata;
                `HWM_REG_ALARM_MASK: alarm_mask <= io_req_i.wdata;
                `HWM_REG_ROUTE:    route_reg  <= io_req_i.wdata[2:0];
                default: ;
            endcase
        end
    end

    assign raw_events = {intr_sync[1], out_of_range};

    // Read clears status; a new event in the same cycle still sticks
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            alarm_status <= 8'h00;
        end else if (data_rd && index == `HWM_REG_ALARM_STATUS && !bank) begin
            alarm_status <= raw_events;
        end else begin
            alarm_status <= alarm_status | raw_events;
        end
    end

    assign combined_event = |(alarm_status & ~alarm_mask);

    always_comb begin
        next_read = 8'h00;
        if (bank) begin
            if (index == `HWM_REG_TEMP2_HIGH)
                next_read = temp2_r[8:1];
            else if (index == `HWM_REG_TEMP2_LOW)
                next_read = {temp2_r[0], 7'h00};
            else if (index == `HWM_REG_BANK_SEL)
                next_read = {7'h00, bank};
        end else begin
            for (int i = 0; i < NUM_VOLT; i++) begin
                if (index == `HWM_REG_VOLT_BASE + 7'(i))
                    next_read = volt_r[i];
                if (index == `HWM_REG_HIGH_LIM_BASE + 7'(2 * i))
                    next_read = high_lim[i];
                if (index == `HWM_REG_LOW_LIM_BASE + 7'(2 * i))
                    next_read = low_lim[i];
            end
            for (int f = 0; f < NUM_FAN; f++) begin
                if (index == `HWM_REG_FAN_BASE + 7'(f))
                    next_read = fan_count_i[f];
            end
            unique case (index)
                `HWM_REG_TEMP1:        next_read = temp1_r;
                `HWM_REG_CONFIG:       next_read = config_reg;
                `HWM_REG_ALARM_STATUS: next_read = alarm_status;
                `HWM_REG_ALARM_MASK:   next_read = alarm_mask;
                `HWM_REG_ROUTE:        next_read = {5'h00, route_reg};
                `HWM_REG_BANK_SEL:     next_read = {7'h00, bank};
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            io_rdata_o <= 8'h00;
        end else if (io_req_i.rd && idx_hit) begin
            io_rdata_o <= {1'b0, index};
        end else if (data_rd) begin
            io_rdata_o <= next_read;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            system_mgmt_alarm_out_o  <= 1'b0;
            power_event_out_o        <= 1'b0;
            serirq_alarm_o           <= 1'b0;
            overtemp_out_o           <= 1'b0;
            general_protection_out_o <= 1'b0;
            beep_o                   <= 1'b0;
        end else begin
            // Route select (PME bit) steering of the single event, gated by enable; ACPI bit unused
            system_mgmt_alarm_out_o <= combined_event && !route_reg[`HWM_ROUTE_PME_BIT]
                                       && route_reg[`HWM_ROUTE_OE_BIT];
            power_event_out_o <= combined_event && route_reg[`HWM_ROUTE_PME_BIT]
                                 && route_reg[`HWM_ROUTE_OE_BIT];
            serirq_alarm_o <= combined_event && !route_reg[`HWM_ROUTE_PME_BIT]
                              && route_reg[`HWM_ROUTE_OE_BIT];
            overtemp_out_o <= $signed(temp2_r) > $signed(`HWM_TEMP2_OVT_LIMIT);
            general_protection_out_o <= combined_event && config_reg[`HWM_CFG_GPO_BIT];
            beep_o <= combined_event && config_reg[`HWM_CFG_BEEP_BIT];
        end
    end
endmodule

// [bench/hwm_readout_asserts.sv]
module hwm_readout_chk (
    input wire logic                 clk_i,
    input wire logic                 sys_rst_i,
    input wire hwm_pkg::hwm_io_req_t io_req_i,
    input wire logic [7:0]           io_rdata_o,
    input wire logic                 io_hit_o,
    input wire logic [2:0]           idx_low_cfg_i,
    input wire logic [2:0]           data_low_cfg_i,
    input wire logic                 system_mgmt_alarm_out_o,
    input wire logic                 power_event_out_o,
    input wire logic                 serirq_alarm_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    logic acc;
    assign acc = io_req_i.wr || io_req_i.rd;
    AST_EVT_EXCL: assert property (!(system_mgmt_alarm_out_o && power_event_out_o))
        else $error("both event outputs high");
    AST_SERIRQ: assert property (serirq_alarm_o == system_mgmt_alarm_out_o)
        else $error("serial alarm differs");
    AST_IDX_WR: assert property (io_req_i.wr && io_req_i.addr == {13'h0052, idx_low_cfg_i}
        |-> io_hit_o) else $error("index write missed");
    AST_DATA_RD: assert property (io_req_i.rd && io_req_i.addr == {13'h0052, data_low_cfg_i}
        |-> io_hit_o) else $error("data read missed");
    AST_DATA_WR: assert property (io_req_i.wr && io_req_i.addr == {13'h0052, data_low_cfg_i}
        |-> io_hit_o) else $error("data write missed");
    AST_MISS: assert property (acc && io_req_i.addr[15:3] != 13'h0052 |-> !io_hit_o)
        else $error("foreign port decoded");
    AST_RD_HOLD: assert property (!(io_req_i.rd && io_hit_o) |=> $stable(io_rdata_o))
        else $error("read data moved");
    AST_RST_QUIET: assert property ($fell(sys_rst_i) |-> !(system_mgmt_alarm_out_o || power_event_out_o))
        else $error("event out of reset");
    cover property ($rose(system_mgmt_alarm_out_o));
    cover property ($rose(power_event_out_o));
    cover property (acc && !io_hit_o);
endmodule

bind hwm_readout hwm_readout_chk chk_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .io_req_i(io_req_i), .io_rdata_o(io_rdata_o), .io_hit_o(io_hit_o),
    .idx_low_cfg_i(idx_low_cfg_i), .data_low_cfg_i(data_low_cfg_i),
    .system_mgmt_alarm_out_o(system_mgmt_alarm_out_o),
    .power_event_out_o(power_event_out_o), .serirq_alarm_o(serirq_alarm_o));

// [bench/hwm_host_model.sv]
module hwm_host_model (
    input  wire logic           clk_i,
    input  wire logic [7:0]     rdata_i,
    output hwm_pkg::hwm_io_req_t req_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial req_o = '0;
    // Idle address inverted so a stale port never looks valid
    task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk_i);
        req_o <= '{1'b1, 1'b0, a, d};
        @(negedge clk_i);
        req_o <= '{1'b0, 1'b0, ~a, ~d};
    endtask
    task automatic io_rd(input logic [15:0] a, output logic [7:0] d);
        @(negedge clk_i);
        req_o <= '{1'b0, 1'b1, a, 8'h00};
        @(negedge clk_i);
        req_o <= '{1'b0, 1'b0, ~a, 8'hFF};
        @(negedge clk_i);
        d = rdata_i;
    endtask
endmodule

// [bench/testbench.sv]
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic                 clk      = 1'b0;
    logic                 rst      = 1'b1;
    logic                 vvalid   = 1'b0;
    logic [2:0]           idx_low  = 3'h5;
    logic [2:0]           data_low = 3'h6;
    logic [7:0]           t1       = 8'h00;
    logic [8:0]           t2       = 9'h000;
    logic [7:0]           volt [7] = '{default: 8'h00};
    logic [7:0]           fan [2]  = '{8'hA0, 8'hA1};
    logic [7:0]           rdata;
    logic                 hit, smi, pme, ovt, beep, gpo;
    logic                 intr     = 1'b0;
    hwm_pkg::hwm_io_req_t req;
    int                   fail_count = 0;
    int                   compares   = 0;
    int                   cyc        = 0;
    hwm_host_model host_u (.clk_i(clk), .rdata_i(rdata), .req_o(req));
    hwm_readout dut_u (
        .clk_i(clk), .sys_rst_i(rst), .io_req_i(req), .io_rdata_o(rdata), .io_hit_o(hit),
        .idx_low_cfg_i(idx_low), .data_low_cfg_i(data_low), .volt_code_i(volt),
        .volt_valid_i(vvalid), .fan_count_i(fan), .temp1_code_i(t1), .temp2_code_i(t2),
        .intrusion_i(intr), .system_mgmt_alarm_out_o(smi), .power_event_out_o(pme),
        .serirq_alarm_o(), .overtemp_out_o(ovt), .general_protection_out_o(gpo), .beep_o(beep)
    );
    always #25 clk = ~clk;
    task automatic end_of_test();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wreg(input logic [7:0] i, input logic [7:0] d);
        host_u.io_wr({13'h0052, idx_low}, i);
        host_u.io_wr({13'h0052, data_low}, d);
    endtask
    task automatic rreg(input logic [7:0] i, output logic [7:0] d);
        host_u.io_wr({13'h0052, idx_low}, i);
        host_u.io_rd({13'h0052, data_low}, d);
    endtask
    task automatic rchk(input logic [7:0] i, input logic [7:0] e);
        logic [7:0] d;
        rreg(i, d);
        chk("data", e, d);
    endtask
    // Ceiling well above the roughly 140 cycles the sequence needs
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fail_count++;
            end_of_test();
        end
    end
    initial begin
        logic [7:0] d;
        repeat (6) @(negedge clk);
        rst = 1'b0;
        chk("evt", 8'h00, {7'h00, smi | pme});
        wreg(8'h2B, 8'h10);
        wreg(8'h43, 8'hFE);
        wreg(8'h45, 8'h02);
        for (int i = 0; i < 7; i++) volt[i] = 8'h30 + 8'(i);
        t1 = 8'h7D;
        t2 = 9'h0FB;
        vvalid = 1'b1;
        @(negedge clk);
        vvalid = 1'b0;
        repeat (3) @(negedge clk);
        chk("smi", 8'h01, {7'h00, smi});
        chk("pme", 8'h00, {7'h00, pme});
        wreg(8'h45, 8'h03);
        repeat (3) @(negedge clk);
        chk("pme", 8'h01, {7'h00, pme});
        chk("smi", 8'h00, {7'h00, smi});
        wreg(8'h45, 8'h01);
        repeat (3) @(negedge clk);
        chk("off", 8'h00, {7'h00, smi | pme});
        chk("ovt", 8'h01, {7'h00, ovt});
        wreg(8'h40, 8'h06);
        repeat (3) @(negedge clk);
        chk("gpo", 8'h01, {7'h00, gpo});
        chk("beep", 8'h01, {7'h00, beep});
        wreg(8'h43, 8'hFF);
        repeat (3) @(negedge clk);
        chk("beep", 8'h00, {7'h00, beep});
        chk("gpo", 8'h00, {7'h00, gpo});
        for (int i = 0; i < 7; i++) rchk(8'h20 + 8'(i), 8'h30 + 8'(i));
        rchk(8'h28, 8'hA0);
        rchk(8'h29, 8'hA1);
        rchk(8'h27, 8'h7D);
        wreg(8'h4E, 8'h01);
        rchk(8'h50, 8'h7D);
        rreg(8'h51, d);
        chk("lsb", 8'h80, d & 8'h80);
        host_u.io_wr(16'h1295, 8'h20);
        host_u.io_rd({13'h0052, idx_low}, d);
        chk("index", 8'h51, d);
        wreg(8'h4E, 8'h00);
        idx_low = 3'h1;
        data_low = 3'h2;
        rchk(8'h27, 8'h7D);
        wreg(8'h2E, 8'h40);
        intr = 1'b1;
        repeat (4) @(negedge clk);
        rchk(8'h41, 8'h83);
        end_of_test();
    end
endmodule
